// ==== shared/twsl_pkg.sv ====
// Purpose: shared constants and types of the two-wire slave port
// Assumes: core clock of 125 MHz, bus clock at most 400 kHz
// Notes:   control byte is type code, three select bits, direction bit
package twsl_pkg;
    // core clock and bus rates
    localparam int CLK_MHZ = 125;
    localparam int SCL_STD_KHZ = 100;
    localparam int SCL_FAST_KHZ = 400;
    // shortest bus clock period in core cycles, rounded down
    localparam int SCL_MIN_CYC = CLK_MHZ * 1000 / SCL_FAST_KHZ;
    // byte framing counts
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    // control byte field positions
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int DIR_BIT = 0;
    // command codes
    localparam logic [7:0] CMD_ADDR = 8'h0D;
    localparam logic [7:0] CMD_STORE = 8'h3F;
    // bus address register layout
    localparam int ADDR_W = 5;
    localparam int COMMIT_BIT = 4;
    localparam int ASEL_MSB = 2;
    localparam logic [4:0] ADDR_RST = 5'h00;
    localparam logic [2:0] ADDR_PAD = 3'h0;
    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CTRL,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_TXACK,
        ST_SKIP
    } twsl_state_t;
endpackage

// ==== shared/twsl_link_if.sv ====
// Purpose: carries sampled bits from the bus clock domain to the core
// Assumes: bit_val is stable whenever tgl is seen to change
// Notes:   one toggle of tgl per rising bus clock edge
`timescale 1ns/1ps
interface twsl_link_if;
    logic bit_val; // data level at the last rising bus clock
    logic tgl; // flips once per rising bus clock
    modport link (output bit_val, output tgl);
    modport core (input bit_val, input tgl);
endinterface

// ==== verilog/twsl_sync.sv ====
// Purpose: two-stage synchroniser for a group of levels
// Assumes: inputs are asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module twsl_sync
    import twsl_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // first stage, may go metastable

    // two flip-flops in series
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // twsl_sync

// ==== verilog/twsl_link.sv ====
// Purpose: samples the data pin on each rising bus clock edge
// Assumes: bus clock stands still between frames
// Notes:   the core sees each bit through a toggle crossing
`timescale 1ns/1ps
module twsl_link
    import twsl_pkg::*;
(
    // link clock and reset
    input wire logic scl_clk,
    input wire logic rst,
    // raw data pin
    input wire logic sda_i,
    // toward the core domain
    twsl_link_if.link lnk
);
    // capture the bit on the rising clock edge and flag it on that same edge
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            lnk.bit_val <= 1'b0;
            lnk.tgl <= 1'b0;
        end else begin
            lnk.bit_val <= sda_i;
            lnk.tgl <= ~lnk.tgl;
        end
    end
endmodule // twsl_link

// ==== verilog/twsl_slave.sv ====
// Purpose: slave side of a two-wire serial port with device select
// Assumes: bus clock pin also clocks the bit sampler; no clock stretching
// Notes:   data pin is open drain, driven low or released
// Summary of operation
// - data stable while clock high
// - falling data, clock high: start
// - rising data, clock high: stop
// - eight bits then receiver acknowledge bit
// - any number of bytes per transfer
// - works at 100 and 400 kHz
// - acknowledge low through whole clock high
// - busy storing: refuse with not-acknowledge
// - master nack ends read; release data
// - write: address then data, each acknowledged
// - repeated start begins next transfer directly
// - control byte top nibble: type code
// - next three bits match device select
// - new select value takes effect immediately
// - last control bit: 1 read, 0 write
// - acknowledge only when type and select match
// - transmitter: ack address, then shift data out
// - address register write always stores settings
// - commit bit 0 stores every write
// - store starts only after stop
`timescale 1ns/1ps
module twsl_slave
    import twsl_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = 4'hA // arbitrary value
) (
    // clocks and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_clk,
    // data pin
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // store engine handshake
    input wire logic nv_busy,
    output logic nv_store,
    // register traffic
    input wire logic [7:0] rd_data,
    output logic rd_req,
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    output logic [7:0] wr_data,
    output logic wr_valid,
    // status
    output logic xfer_stop,
    output logic [2:0] dev_sel,
    output logic nv_commit_mode_bit,
    output logic active
);
    twsl_link_if lnk (); // bit crossing carrier
    logic scl_s, sda_s, tgl_s; // synchronised levels
    logic scl_d, sda_d, tgl_d; // one cycle older
    twsl_state_t st_r, st_nxt; // protocol state
    logic [3:0] cnt_r, cnt_nxt; // bits in current byte
    logic [7:0] sh_r, sh_nxt; // receive shifter
    logic [7:0] tx_r, tx_nxt; // transmit shifter
    logic rw_r, rw_nxt; // direction of transfer
    logic first_r, first_nxt; // next write byte is the command
    logic mack_r, mack_nxt; // master acknowledged last byte
    logic oe_r, oe_nxt; // data pin pulled low
    logic pend_r, pend_nxt; // store waiting for stop
    logic [4:0] addr_r, addr_nxt; // bus address register
    logic [7:0] cmd_r, cmd_nxt; // last command byte
    logic [7:0] wd_r, wd_nxt; // last written data byte
    logic cmdv_r, cmdv_nxt; // command strobe
    logic wv_r, wv_nxt; // data strobe
    logic rq_r, rq_nxt; // read data taken
    logic stop_r, stop_nxt; // stop seen
    logic store_r, store_nxt; // store launch
    logic load; // load transmit shifter

    // bit sampler on the bus clock
    twsl_link u_link (
        .scl_clk(scl_clk),
        .rst(rst),
        .sda_i(sda_i),
        .lnk(lnk.link)
    );

    // pins and bit toggle into the core domain, fast enough for 400 kHz
    twsl_sync #(.W(3)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({scl_clk, sda_i, lnk.tgl}),
        .q({scl_s, sda_s, tgl_s})
    );

    // previous synchronised levels for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // same level as the synchroniser reset, so no false edge follows
            scl_d <= 1'b0;
            sda_d <= 1'b0;
            tgl_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            tgl_d <= tgl_s;
        end
    end

    // bus conditions and events
    wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;
    wire bit_ev = tgl_s ^ tgl_d;
    wire scl_fall = scl_d & ~scl_s;
    wire [7:0] sh_in = {sh_r[6:0], lnk.bit_val};
    wire rx_state = (st_r == ST_CTRL) || (st_r == ST_RX);
    wire byte_done = bit_ev && rx_state && (cnt_r == BYTE_BITS - CNT_ONE);
    wire type_hit = sh_in[TYPE_MSB:TYPE_LSB] == TYPE_CODE;
    wire sel_hit = sh_in[SEL_MSB:SEL_LSB] == addr_r[ASEL_MSB:0];
    wire ack_ok = ~nv_busy;
    wire cmd_is_addr = cmd_r == CMD_ADDR;
    wire [7:0] tx_byte = cmd_is_addr ? {ADDR_PAD, addr_r} : rd_data;

    // next-state logic of the protocol engine
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        rw_nxt = rw_r;
        first_nxt = first_r;
        mack_nxt = mack_r;
        oe_nxt = oe_r;
        pend_nxt = pend_r;
        addr_nxt = addr_r;
        cmd_nxt = cmd_r;
        wd_nxt = wd_r;
        cmdv_nxt = 1'b0;
        wv_nxt = 1'b0;
        rq_nxt = 1'b0;
        stop_nxt = 1'b0;
        store_nxt = 1'b0;
        load = 1'b0;
        if (start_ev) begin
            // start or repeated start: expect a control byte
            st_nxt = ST_CTRL;
            cnt_nxt = CNT_ZERO;
            first_nxt = 1'b1;
            oe_nxt = 1'b0;
        end else if (stop_ev) begin
            // stop: release and launch any waiting store
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            stop_nxt = 1'b1;
            if (pend_r) begin
                store_nxt = 1'b1;
                pend_nxt = 1'b0;
            end
        end else begin
            unique case (st_r)
                ST_IDLE, ST_SKIP: begin
                    oe_nxt = 1'b0;
                end
                ST_CTRL, ST_RX: begin
                    // shift in one bit per rising clock
                    if (bit_ev) begin
                        sh_nxt = sh_in;
                        cnt_nxt = cnt_r + CNT_ONE;
                    end
                    if (byte_done) begin
                        cnt_nxt = CNT_ZERO;
                        if (!ack_ok) begin
                            st_nxt = ST_SKIP;
                        end else if (st_r == ST_CTRL) begin
                            // control byte: answer only on a full match
                            st_nxt = (type_hit && sel_hit) ? ST_ACK : ST_SKIP;
                            rw_nxt = sh_in[DIR_BIT];
                        end else begin
                            st_nxt = ST_ACK;
                            if (first_r) begin
                                // first write byte is the command
                                cmd_nxt = sh_in;
                                cmdv_nxt = 1'b1;
                                first_nxt = 1'b0;
                                if (sh_in == CMD_STORE) begin
                                    pend_nxt = 1'b1;
                                end
                            end else begin
                                wd_nxt = sh_in;
                                wv_nxt = 1'b1;
                                if (cmd_is_addr) begin
                                    addr_nxt = sh_in[ADDR_W-1:0];
                                    pend_nxt = 1'b1;
                                end else if (!addr_r[COMMIT_BIT]) begin
                                    pend_nxt = 1'b1;
                                end
                            end
                        end
                    end
                end
                ST_ACK: begin
                    // pull low from one falling edge to the next
                    if (scl_fall) begin
                        if (!oe_r) begin
                            oe_nxt = 1'b1;
                        end else if (rw_r) begin
                            load = 1'b1;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    // count bits seen by the master
                    if (bit_ev) begin
                        cnt_nxt = cnt_r + CNT_ONE;
                    end
                    if (scl_fall) begin
                        if (cnt_r == BYTE_BITS) begin
                            st_nxt = ST_TXACK;
                            oe_nxt = 1'b0;
                            cnt_nxt = CNT_ZERO;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            oe_nxt = ~tx_r[6];
                        end
                    end
                end
                ST_TXACK: begin
                    // sample the master answer, released meanwhile
                    oe_nxt = 1'b0;
                    if (bit_ev) begin
                        mack_nxt = ~lnk.bit_val;
                        cnt_nxt = CNT_ONE;
                    end
                    if (scl_fall && (cnt_r != CNT_ZERO)) begin
                        if (mack_r) begin
                            load = 1'b1;
                        end else begin
                            st_nxt = ST_SKIP;
                        end
                    end
                end
            endcase
        end
        // start a new byte out, first bit driven now
        if (load) begin
            st_nxt = ST_TX;
            tx_nxt = tx_byte;
            oe_nxt = ~tx_byte[7];
            rq_nxt = 1'b1;
            cnt_nxt = CNT_ZERO;
        end
    end

    // state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            mack_r <= 1'b0;
            oe_r <= 1'b0;
            pend_r <= 1'b0;
            addr_r <= ADDR_RST;
            cmd_r <= 8'h00;
            wd_r <= 8'h00;
            cmdv_r <= 1'b0;
            wv_r <= 1'b0;
            rq_r <= 1'b0;
            stop_r <= 1'b0;
            store_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            rw_r <= rw_nxt;
            first_r <= first_nxt;
            mack_r <= mack_nxt;
            oe_r <= oe_nxt;
            pend_r <= pend_nxt;
            addr_r <= addr_nxt;
            cmd_r <= cmd_nxt;
            wd_r <= wd_nxt;
            cmdv_r <= cmdv_nxt;
            wv_r <= wv_nxt;
            rq_r <= rq_nxt;
            stop_r <= stop_nxt;
            store_r <= store_nxt;
        end
    end

    // outputs
    assign sda_o = 1'b0;
    assign sda_oe = oe_r;
    assign nv_store = store_r;
    assign rd_req = rq_r;
    assign cmd_byte = cmd_r;
    assign cmd_valid = cmdv_r;
    assign wr_data = wd_r;
    assign wr_valid = wv_r;
    assign xfer_stop = stop_r;
    assign dev_sel = addr_r[ASEL_MSB:0];
    assign nv_commit_mode_bit = addr_r[COMMIT_BIT];
    assign active = (st_r != ST_IDLE) && (st_r != ST_SKIP);

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    start_ctrl_a: assert property (start_ev |=> st_r == ST_CTRL && !sda_oe)
        else $error("start not followed by control byte state");
    stop_idle_a: assert property (stop_ev |=> st_r == ST_IDLE ##1 !sda_oe)
        else $error("stop did not end the transfer");
    busy_nack_a: assert property (byte_done && nv_busy |=> st_r == ST_SKIP [*2])
        else $error("byte taken while store busy");
    type_gate_a: assert property (byte_done && st_r == ST_CTRL && !type_hit
        |=> st_r == ST_SKIP)
        else $error("wrong type code accepted");
    sel_gate_a: assert property (byte_done && st_r == ST_CTRL && !sel_hit
        |=> st_r == ST_SKIP)
        else $error("wrong device select accepted");
    skip_free_a: assert property (st_r == ST_SKIP && $past(st_r) == ST_SKIP |-> !sda_oe)
        else $error("data pin driven while not addressed");
    ack_hold_a: assert property (st_r == ST_ACK && sda_oe && scl_s |=> sda_oe)
        else $error("acknowledge not held low");
    store_stop_a: assert property (nv_store |-> $past(stop_ev) && $past(pend_r))
        else $error("store launched outside a stop");
    addr_store_a: assert property (wv_r && $past(cmd_is_addr) |-> pend_r)
        else $error("address write did not arm a store");
    rd_release_a: assert property (st_r == ST_TXACK |-> !sda_oe)
        else $error("data pin held during master answer");
    bit_count_a: assert property (cnt_r <= BYTE_BITS)
        else $error("bit count out of range");

    write_cov: cover property (wv_r ##[1:1000] stop_r);
    read_cov: cover property (rq_r ##[1:1000] st_r == ST_SKIP);
    restart_cov: cover property (cmdv_r ##[1:1000] start_ev);
endmodule // twsl_slave

// ==== verification/twsl_mst_model.sv ====
// Purpose: bus master model driving the two-wire slave port
// Assumes: open-drain data line with pull-up, resolved in the bench
// Notes:   clock stands high between frames; quarter period steps
`timescale 1ns/1ps
module twsl_mst_model (
    // bus pins
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    localparam realtime QTR = 31.25; // quarter of a 125 ns bus period
    // idle bus: both lines high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one pulse: data set while clock low, sampled early and late in high
    task automatic bit_cyc(input logic b, output logic s);
        sda_pull = ~b;
        #QTR scl = 1'b1;
        #2 s = sda;
        #(2 * QTR - 4) s = s | sda;
        #2 scl = 1'b0;
        #QTR;
    endtask
    // start or repeated start: data falls while clock high
    task automatic bus_start();
        sda_pull = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_pull = 1'b1;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    // stop: data rises while clock high, then bus rests idle
    task automatic bus_stop();
        sda_pull = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_pull = 1'b0;
        #(4 * QTR);
    endtask
    // eight bits msb first, then a released acknowledge pulse
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'b1, s);
        ack = ~s;
    endtask
    // read eight bits, then acknowledge or withhold it
    task automatic recv_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            d[i] = s;
        end
        bit_cyc(~give_ack, s);
    endtask
endmodule // twsl_mst_model

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the two-wire slave port
// Assumes: master model drives the bus; bench plays the register side
// Notes:   expected pulses are queued by the driver, popped by a monitor
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top
    import twsl_pkg::*;
;
    localparam logic [3:0] TC = 4'h6; // type code, arbitrary value
    logic clk, rst, nv_busy, sda_o, sda_oe, nv_store, rd_req, cmd_valid;
    logic wr_valid, xfer_stop, active, nv_commit_mode_bit, scl, m_pull;
    logic [7:0] rd_data, cmd_byte, wr_data;
    logic [2:0] dev_sel;
    wire sda_w;
    logic [11:0] exp_q[$]; // queued {kind, value} notes
    logic [7:0] rv[0:7]; // bytes served for reads
    logic [7:0] bad[0:3] = '{{~TC, 3'h0, 1'b0}, {TC, 3'h1, 1'b0},
        {TC ^ 4'h8, 3'h0, 1'b1}, {TC, 3'h4, 1'b1}}; // mismatching control bytes
    int ridx = 0;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 84898;
    // pull-up unless someone pulls low
    assign sda_w = ~(m_pull | (sda_oe & ~sda_o));
    twsl_slave #(.TYPE_CODE(TC)) u_twsl_slave (.clk(clk), .rst(rst), .scl_clk(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .nv_busy(nv_busy),
        .nv_store(nv_store), .rd_data(rd_data), .rd_req(rd_req), .cmd_byte(cmd_byte),
        .cmd_valid(cmd_valid), .wr_data(wr_data), .wr_valid(wr_valid),
        .xfer_stop(xfer_stop), .dev_sel(dev_sel),
        .nv_commit_mode_bit(nv_commit_mode_bit), .active(active));
    twsl_mst_model u_twsl_mst_model (.scl(scl), .sda_pull(m_pull), .sda(sda_w));
    // core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // serve the next read byte once the port has taken one
    always @(negedge clk) begin
        if (rd_req === 1'b1) begin
            ridx <= ridx + 1;
            rd_data <= rv[ridx + 1];
        end
    end
    // compare a pulse against the oldest note
    task automatic take(input logic [11:0] got);
        logic [11:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hFFF;
        `CHK(got, e)
    endtask
    // monitor: store before stop when both pulse together
    always @(negedge clk) begin
        if (cmd_valid === 1'b1) begin
            take({4'h1, cmd_byte});
        end
        if (wr_valid === 1'b1) begin
            take({4'h2, wr_data});
        end
        if (nv_store === 1'b1) begin
            take(12'h300);
        end
        if (xfer_stop === 1'b1) begin
            take(12'h400);
        end
    end
    task automatic tend(input string n);
        $display("test done: %s", n);
    endtask
    // write frame: control, command, n data bytes (first is d0), stop
    task automatic wr_frame(input logic [7:0] ctl, input logic [7:0] cmd,
        input logic [7:0] d0, input int n, input logic ok, input logic st);
        logic ack;
        logic [7:0] b;
        u_twsl_mst_model.bus_start();
        u_twsl_mst_model.send_byte(ctl, ack);
        `CHK(ack, ok)
        `CHK(active, ok)
        if (ok) begin
            exp_q.push_back({4'h1, cmd});
        end
        u_twsl_mst_model.send_byte(cmd, ack);
        `CHK(ack, ok)
        for (int i = 0; i < n; i++) begin
            b = (i == 0) ? d0 : 8'($random(seed));
            if (ok) begin
                exp_q.push_back({4'h2, b});
            end
            u_twsl_mst_model.send_byte(b, ack);
            `CHK(ack, ok)
        end
        if (st) begin
            exp_q.push_back(12'h300);
        end
        exp_q.push_back(12'h400);
        u_twsl_mst_model.bus_stop();
        `CHK(active, 1'b0)
    endtask
    // read: command write, repeated start, n bytes, last one refused
    task automatic rd_frame(input logic [2:0] sel, input logic [7:0] cmd,
        input int n, input logic [7:0] e0);
        logic ack;
        logic [7:0] b;
        u_twsl_mst_model.bus_start();
        u_twsl_mst_model.send_byte({TC, sel, 1'b0}, ack);
        exp_q.push_back({4'h1, cmd});
        u_twsl_mst_model.send_byte(cmd, ack);
        u_twsl_mst_model.bus_start();
        u_twsl_mst_model.send_byte({TC, sel, 1'b1}, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            u_twsl_mst_model.recv_byte(i < n - 1, b);
            `CHK(b, (cmd == CMD_ADDR) ? e0 : rv[i])
        end
        `CHK(sda_oe, 1'b0)
        exp_q.push_back(12'h400);
        u_twsl_mst_model.bus_stop();
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        nv_busy = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rv[i] = 8'($random(seed));
        end
        rd_data = rv[0];
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        `CHK(dev_sel, 3'h0)
        `CHK(nv_commit_mode_bit, 1'b0)
        `CHK(sda_oe, 1'b0)
        tend("reset");
        wr_frame({TC, 3'h0, 1'b0}, 8'h08, 8'h5A, 3, 1'b1, 1'b1);
        tend("write");
        foreach (bad[i]) begin
            wr_frame(bad[i], 8'h08, 8'h00, 1, 1'b0, 1'b0);
        end
        tend("mismatch");
        @(negedge clk) nv_busy = 1'b1;
        wr_frame({TC, 3'h0, 1'b0}, 8'h08, 8'h11, 1, 1'b0, 1'b0);
        @(negedge clk) nv_busy = 1'b0;
        tend("busy");
        wr_frame({TC, 3'h0, 1'b0}, CMD_ADDR, 8'hF5, 1, 1'b1, 1'b1);
        `CHK(dev_sel, 3'h5)
        `CHK(nv_commit_mode_bit, 1'b1)
        wr_frame({TC, 3'h0, 1'b0}, 8'h08, 8'h00, 1, 1'b0, 1'b0);
        wr_frame({TC, 3'h5, 1'b0}, 8'h08, 8'h3C, 2, 1'b1, 1'b0);
        wr_frame({TC, 3'h5, 1'b0}, CMD_STORE, 8'h00, 0, 1'b1, 1'b1);
        tend("address");
        rd_frame(3'h5, 8'h08, 3, 8'h00);
        rd_frame(3'h5, CMD_ADDR, 1, 8'h15);
        tend("read");
        for (int i = 0; i < 500 && exp_q.size() > 0; i++) begin
            @(negedge clk);
        end
        if (exp_q.size() > 0) begin
            error_cnt++;
        end
        final_report();
    end
endmodule // tb_top
